//--- rtl/thermal_alert_qualifier_consts.svh
`ifndef THERMAL_ALERT_QUALIFIER_CONSTS_SVH
`define THERMAL_ALERT_QUALIFIER_CONSTS_SVH

// register offsets
`define OFS_CFG1 8'h01
`define OFS_CFG2 8'h02
`define OFS_CFG4 8'h04
`define OFS_QUEUE 8'h06
`define OFS_RATE 8'h07
`define OFS_MASK2 8'h09
`define OFS_PCT_LIMIT 8'h19
`define OFS_HYS 8'h1a
`define OFS_PCT_VALUE 8'h4e
`define OFS_STATUS2 8'h50

// field positions
`define CFG1_PIN_INPUT 2
`define CFG1_COMP_MODE 3
`define CFG2_BOOST_DIS 1
`define CFG4_WIN_LSB 4
`define CFG4_REF_SEL 7
`define MASK2_PCT 4
`define STATUS2_PCT 4

// reset values
`define RST_CFG 8'h00
`define RST_QUEUE 8'h00
`define RST_RATE 8'h08
`define RST_PCT_LIMIT 8'hff
`define RST_HYS 8'h04

// rate codes
`define RATE_MAX 8'h0a
`define RATE_NO_AVG 8'h08

// timing
`define CLK_HZ 25000000
`define SLOWEST_RATE_PERIOD_S 16
`define WINDOW_BASE_US 250000
`define WIN_TICKS 256
`define WIN_CODE_MAX 3'd5

`endif

//--- rtl/thermal_alert_qualifier_pkg.sv
`include "thermal_alert_qualifier_consts.svh"

package thermal_alert_qualifier_pkg;

  // one finished temperature measurement
  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] temp;
    logic [7:0] overtemp_limit;
    logic out_of_limit;
  } meas_s;

  // whole state of the block
  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg4;
    logic [7:0] queue;
    logic [7:0] mask2;
    logic [7:0] pct_limit;
    logic [7:0] hys;
    logic [7:0] rate_pend;
    logic [7:0] rate_act;
    logic [28:0] rate_cnt;
    logic rate_start;
    logic [2:0][2:0] qcnt;
    logic [2:0] chan_out;
    logic [2:0] over;
    logic temp_alert;
    logic pct_status;
    logic [19:0] tick_cnt;
    logic [8:0] tick_num;
    logic [8:0] low_num;
    logic [7:0] pct_value;
    logic [7:0] rdata;
  } state_s;

endpackage

//--- rtl/thermal_alert_qualifier.sv
module thermal_alert_qualifier
  import thermal_alert_qualifier_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYCLES = `SLOWEST_RATE_PERIOD_S * `CLK_HZ,
  parameter int unsigned TICK_BASE_CYCLES =
    (`WINDOW_BASE_US / `WIN_TICKS) * (`CLK_HZ / 1000000)
    + ((`WINDOW_BASE_US % `WIN_TICKS) * (`CLK_HZ / 1000000)) / `WIN_TICKS
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register port from the serial bus engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // queue clear events
  input wire logic alert_response_i,
  input wire logic status1_read_i,
  // measurement results
  input wire logic meas_valid_i,
  input wire meas_s meas_i,
  input wire logic round_done_i,
  // conversion scheduling
  output logic round_start_o,
  output logic averaging_o,
  // alert line, active low level
  output logic alert_n_o,
  // overtemp pin, open drain
  input wire logic overtemp_pin_i,
  output logic overtemp_pin_o,
  output logic overtemp_pin_oe_o,
  // fans and dual-function pin
  output logic fan_boost_o,
  input wire logic [1:0] fan_stall_i,
  output logic fan_fault_o,
  output logic fan_fault_oe_o,
  output logic ref_select_o
);

  state_s st;
  state_s next_st;

  logic [2:0] depth;
  logic [28:0] rate_period;
  logic [19:0] tick_period;
  logic [2:0] win_code;
  logic pin_input;
  logic comp_mode;
  logic pin_low;
  logic tick;
  logic win_end;
  logic [7:0] pct_now;
  logic [8:0] hys_sum;
  logic queue_clear;
  logic [1:0] ch;

  // queue depth field decode
  function automatic logic [2:0] decode_depth(input logic [3:0] f);
    logic [2:0] d;
    d = 3'd1;
    casez (f)
      4'b000?: d = 3'd1;
      4'b001?: d = 3'd2;
      4'b01??: d = 3'd3;
      default: d = 3'd4;
    endcase
    return d;
  endfunction

  // static decodes of configuration
  always_comb
  begin
    depth = decode_depth(st.queue[3:0]);
    pin_input = st.cfg1[`CFG1_PIN_INPUT];
    comp_mode = st.cfg1[`CFG1_COMP_MODE];
    rate_period = 29'(RATE_BASE_CYCLES >> st.rate_act[3:0]);
    win_code = st.cfg4[`CFG4_WIN_LSB+2:`CFG4_WIN_LSB];
    if (win_code > `WIN_CODE_MAX)
    begin
      win_code = `WIN_CODE_MAX;
    end
    tick_period = 20'(TICK_BASE_CYCLES << win_code);
    pin_low = pin_input && !overtemp_pin_i;
    tick = (st.tick_cnt == tick_period - 20'd1);
    win_end = tick && (st.tick_num == 9'(`WIN_TICKS - 1));
    queue_clear = alert_response_i || status1_read_i;
    ch = meas_i.chan;
    hys_sum = {1'b0, meas_i.temp} + {1'b0, st.hys};
  end

  // scaled percentage of the window just ending, 256 ticks map to 0xff
  always_comb
  begin
    if (st.low_num + {8'h00, pin_low} >= 9'(`WIN_TICKS))
    begin
      pct_now = 8'hff;
    end
    else
    begin
      pct_now = 8'(st.low_num + {8'h00, pin_low});
    end
  end

  // next state
  always_comb
  begin
    next_st = st;
    next_st.rate_start = 1'b0;

    // register writes
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `OFS_CFG1: next_st.cfg1 = reg_wdata_i;
        `OFS_CFG2: next_st.cfg2 = reg_wdata_i;
        `OFS_CFG4: next_st.cfg4 = reg_wdata_i;
        `OFS_QUEUE: next_st.queue = reg_wdata_i;
        `OFS_RATE: next_st.rate_pend = reg_wdata_i;
        `OFS_MASK2: next_st.mask2 = reg_wdata_i;
        `OFS_PCT_LIMIT: next_st.pct_limit = reg_wdata_i;
        `OFS_HYS: next_st.hys = reg_wdata_i;
        default: ;
      endcase
    end

    // register reads, unmapped reads give zero
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `OFS_CFG1: next_st.rdata = st.cfg1;
        `OFS_CFG2: next_st.rdata = st.cfg2;
        `OFS_CFG4: next_st.rdata = st.cfg4;
        `OFS_QUEUE: next_st.rdata = st.queue;
        `OFS_RATE: next_st.rdata = st.rate_pend;
        `OFS_MASK2: next_st.rdata = st.mask2;
        `OFS_PCT_LIMIT: next_st.rdata = st.pct_limit;
        `OFS_HYS: next_st.rdata = st.hys;
        `OFS_PCT_VALUE: next_st.rdata = st.pct_value;
        `OFS_STATUS2: next_st.rdata = {3'b000, st.pct_status, 4'h0};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // status 2 clears on its read; a new event below wins
    if (reg_rd_i && reg_addr_i == `OFS_STATUS2)
    begin
      next_st.pct_status = 1'b0;
    end

    // conversion loop timer
    if (st.rate_cnt >= rate_period - 29'd1)
    begin
      next_st.rate_cnt = '0;
      next_st.rate_start = 1'b1;
    end
    else
    begin
      next_st.rate_cnt = st.rate_cnt + 29'd1;
    end

    // rate change waits for the loop in flight; reserved codes ignored
    if (round_done_i && st.rate_pend <= `RATE_MAX)
    begin
      next_st.rate_act = st.rate_pend;
    end

    // queue clears release a latched alert
    if (queue_clear)
    begin
      next_st.qcnt = '0;
      next_st.temp_alert = 1'b0;
    end

    // per-channel queue and overtemp hysteresis
    if (meas_valid_i && ch <= 2'd2)
    begin
      next_st.chan_out[ch] = meas_i.out_of_limit;
      if (meas_i.out_of_limit)
      begin
        if (next_st.qcnt[ch] < 3'd4)
        begin
          next_st.qcnt[ch] = next_st.qcnt[ch] + 3'd1;
        end
        if (!comp_mode && next_st.qcnt[ch] == depth)
        begin
          next_st.temp_alert = 1'b1;
        end
      end
      else
      begin
        next_st.qcnt[ch] = 3'd0;
      end
      if (meas_i.temp > meas_i.overtemp_limit)
      begin
        next_st.over[ch] = 1'b1;
      end
      else if (hys_sum < {1'b0, meas_i.overtemp_limit})
      begin
        next_st.over[ch] = 1'b0;
      end
    end

    // on-time sampling ticks and window
    if (!pin_input)
    begin
      next_st.tick_cnt = '0;
      next_st.tick_num = '0;
      next_st.low_num = '0;
    end
    else if (tick)
    begin
      next_st.tick_cnt = '0;
      if (win_end)
      begin
        next_st.tick_num = '0;
        next_st.low_num = '0;
        next_st.pct_value = pct_now;
        if (pct_now > st.pct_limit)
        begin
          next_st.pct_status = 1'b1;
        end
      end
      else
      begin
        next_st.tick_num = st.tick_num + 9'd1;
        next_st.low_num = st.low_num + {8'h00, pin_low};
      end
      if (pin_low && st.pct_limit == 8'h00)
      begin
        next_st.pct_status = 1'b1;
      end
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 20'd1;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.cfg1 <= `RST_CFG;
      st.cfg2 <= `RST_CFG;
      st.cfg4 <= `RST_CFG;
      st.queue <= `RST_QUEUE;
      st.mask2 <= `RST_CFG;
      st.pct_limit <= `RST_PCT_LIMIT;
      st.hys <= `RST_HYS;
      st.rate_pend <= `RST_RATE;
      st.rate_act <= `RST_RATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs
  always_comb
  begin
    reg_rdata_o = st.rdata;
    round_start_o = st.rate_start;
    averaging_o = (st.rate_act < `RATE_NO_AVG);
    alert_n_o = !((comp_mode ? |st.chan_out : st.temp_alert)
      || (st.pct_status && !st.mask2[`MASK2_PCT]));
    overtemp_pin_o = 1'b0;
    overtemp_pin_oe_o = pin_input ? |(st.over & st.cfg4[2:0])
      : |st.over;
    fan_boost_o = |st.over && !st.cfg2[`CFG2_BOOST_DIS];
    ref_select_o = st.cfg4[`CFG4_REF_SEL];
    fan_fault_o = 1'b0;
    fan_fault_oe_o = !st.cfg4[`CFG4_REF_SEL] && |fan_stall_i;
  end

endmodule // thermal_alert_qualifier

//--- bench/hot_signal_source.sv
module hot_signal_source
(
  // hot request and the block's own drive
  input wire logic assert_i,
  input wire logic drive_i,
  // resolved pin level
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // either pull-down wins over the pull-up
  assign pin_o = !(assert_i || drive_i);
endmodule // hot_signal_source

//--- bench/thermal_alert_qualifier_assertions.sv
module thermal_alert_qualifier_checker
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alert_response_i,
  input wire logic status1_read_i,
  input wire logic meas_valid_i,
  input wire logic round_done_i,
  input wire logic round_start_o,
  input wire logic averaging_o,
  input wire logic alert_n_o,
  input wire logic overtemp_pin_o,
  input wire logic overtemp_pin_oe_o,
  input wire logic fan_boost_o,
  input wire logic [1:0] fan_stall_i,
  input wire logic fan_fault_oe_o,
  input wire logic ref_select_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // dual pin, stall flag and reference use
  fault_sel_a: assert property (ref_select_o |-> !fan_fault_oe_o)
    else $error("dual pin driven as reference");
  stall_flag_a: assert property (!ref_select_o && $stable(fan_stall_i)
    |-> fan_fault_oe_o == (|fan_stall_i))
    else $error("stall flag wrong");
  // open-drain pin only ever pulls low
  pin_level_a: assert property (overtemp_pin_o == 1'b0)
    else $error("pin driven high");
  pin_drive_a: assert property ($changed(overtemp_pin_oe_o)
    |-> $past(meas_valid_i || reg_wr_i))
    else $error("pin drive changed without cause");
  boost_cause_a: assert property ($changed(fan_boost_o)
    |-> $past(meas_valid_i || reg_wr_i))
    else $error("boost changed without cause");
  // alert release needs a clear, a reading or an access
  alert_release_a: assert property ($rose(alert_n_o) |-> $past(alert_response_i
    || status1_read_i || meas_valid_i || reg_wr_i || reg_rd_i))
    else $error("alert released without cause");
  // scheduling
  start_pulse_a: assert property (round_start_o |=> !round_start_o)
    else $error("round start longer than a cycle");
  rate_apply_a: assert property ($changed(averaging_o)
    |-> $past(round_done_i || reg_wr_i))
    else $error("rate applied mid loop");
  rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
endmodule // thermal_alert_qualifier_checker

bind thermal_alert_qualifier thermal_alert_qualifier_checker chk_u (.clock_i, .rst_n_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .alert_response_i, .status1_read_i,
  .meas_valid_i, .round_done_i, .round_start_o, .averaging_o, .alert_n_o,
  .overtemp_pin_o, .overtemp_pin_oe_o, .fan_boost_o, .fan_stall_i,
  .fan_fault_oe_o, .ref_select_o);

//--- bench/thermal_alert_qualifier_tb_top.sv
module thermal_alert_qualifier_tb_top
  import thermal_alert_qualifier_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, meas_valid_i = 0;
  logic round_done_i = 0, alert_response_i = 0, status1_read_i = 0, hot = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [1:0] fan_stall_i = 0;
  meas_s meas_i = '0;
  logic alert_n_o, overtemp_pin_o, overtemp_pin_oe_o, fan_boost_o, fan_fault_o;
  logic fan_fault_oe_o, ref_select_o, round_start_o, averaging_o, overtemp_pin_i;
  int err_total = 0, comparisons = 0;
  // clock and design
  always #20 clock_i = ~clock_i;
  thermal_alert_qualifier #(.RATE_BASE_CYCLES(1024), .TICK_BASE_CYCLES(4)) DUT (.clock_i,
    .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .alert_response_i, .status1_read_i, .meas_valid_i, .meas_i, .round_done_i,
    .round_start_o, .averaging_o, .alert_n_o, .overtemp_pin_i, .overtemp_pin_o,
    .overtemp_pin_oe_o, .fan_boost_o, .fan_stall_i, .fan_fault_o, .fan_fault_oe_o,
    .ref_select_o);
  hot_signal_source hot_u (.assert_i(hot), .drive_i(overtemp_pin_oe_o),
    .pin_o(overtemp_pin_i));
  task close_out;
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    #1 chk("rdata", e, reg_rdata_o);
  endtask
  task ms(input logic [1:0] c, input logic [7:0] t, l, input logic o);
    @(posedge clock_i);
    meas_i <= '{c, t, l, o};
    meas_valid_i <= 1'b1;
    @(posedge clock_i);
    meas_valid_i <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  task clr(input logic ara);
    @(posedge clock_i);
    alert_response_i <= ara;
    status1_read_i <= !ara;
    @(posedge clock_i);
    alert_response_i <= 1'b0;
    status1_read_i <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  // reset values, read-only and unmapped places
  task reset_values;
    rd(8'h19, 8'hff);
    rd(8'h1a, 8'h04);
    rd(8'h07, 8'h08);
    rd(8'h06, 8'h00);
    wr(8'h4e, 8'h55);
    rd(8'h4e, 8'h00);
    rd(8'h30, 8'h00);
  endtask
  // per-channel queues, clears and comparator mode
  task queue_filter;
    wr(8'h06, 8'h03);
    ms(2'd0, 8'h10, 8'h40, 1'b1);
    ms(2'd1, 8'h10, 8'h40, 1'b1);
    chk("alert_n", 1'b1, alert_n_o);
    ms(2'd0, 8'h10, 8'h40, 1'b1);
    chk("alert_n", 1'b0, alert_n_o);
    clr(1'b0);
    chk("alert_n", 1'b1, alert_n_o);
    ms(2'd1, 8'h10, 8'h40, 1'b1);
    chk("alert_n", 1'b1, alert_n_o);
    ms(2'd1, 8'h10, 8'h40, 1'b1);
    chk("alert_n", 1'b0, alert_n_o);
    clr(1'b1);
    chk("alert_n", 1'b1, alert_n_o);
    // clear the last readings of channels 0 and 1 so comparator mode starts quiet
    ms(2'd0, 8'h10, 8'h40, 1'b0);
    ms(2'd1, 8'h10, 8'h40, 1'b0);
    chk("alert_n", 1'b1, alert_n_o);
    wr(8'h01, 8'h08);
    chk("alert_n", 1'b1, alert_n_o);
    ms(2'd2, 8'h10, 8'h40, 1'b1);
    chk("alert_n", 1'b0, alert_n_o);
    ms(2'd2, 8'h10, 8'h40, 1'b0);
    chk("alert_n", 1'b1, alert_n_o);
    wr(8'h01, 8'h00);
  endtask
  // pin output, hysteresis, boost, input mode and channel mask
  task pin_output;
    ms(2'd1, 8'h50, 8'h40, 1'b0);
    chk("pin_oe", 1'b1, overtemp_pin_oe_o);
    chk("boost", 1'b1, fan_boost_o);
    ms(2'd1, 8'h3d, 8'h40, 1'b0);
    chk("pin_oe", 1'b1, overtemp_pin_oe_o);
    ms(2'd1, 8'h3b, 8'h40, 1'b0);
    chk("pin_oe", 1'b0, overtemp_pin_oe_o);
    wr(8'h02, 8'h02);
    ms(2'd1, 8'h50, 8'h40, 1'b0);
    chk("boost", 1'b0, fan_boost_o);
    wr(8'h01, 8'h04);
    chk("pin_oe", 1'b0, overtemp_pin_oe_o);
    wr(8'h04, 8'h02);
    chk("pin_oe", 1'b1, overtemp_pin_oe_o);
    ms(2'd1, 8'h30, 8'h40, 1'b0);
    wr(8'h04, 8'h00);
  endtask
  // on-time percentage over whole windows, then masked
  task pct_window;
    wr(8'h19, 8'h80);
    hot <= 1'b1;
    repeat (2100) @(posedge clock_i);
    rd(8'h4e, 8'hff);
    chk("alert_n", 1'b0, alert_n_o);
    wr(8'h09, 8'h10);
    chk("alert_n", 1'b1, alert_n_o);
    rd(8'h50, 8'h10);
    hot <= 1'b0;
    wr(8'h01, 8'h00);
  endtask
  // new rate waits for the end of the loop
  task rate_change;
    int n;
    n = 0;
    wr(8'h07, 8'h07);
    chk("averaging", 1'b0, averaging_o);
    @(posedge clock_i);
    round_done_i <= 1'b1;
    @(posedge clock_i);
    round_done_i <= 1'b0;
    #1 chk("averaging", 1'b1, averaging_o);
    rd(8'h07, 8'h07);
    // code 7 gives a loop start every 8 cycles with the shortened base period
    repeat (64)
    begin
      @(posedge clock_i);
      if (round_start_o === 1'b1)
      begin
        n++;
      end
    end
    chk("round_starts", 8'h08, 8'(n));
  endtask
  // dual pin as stall flag, then as reference
  task fan_fault;
    fan_stall_i <= 2'b10;
    repeat (3) @(posedge clock_i);
    #1 chk("fault_oe", 1'b1, fan_fault_oe_o);
    wr(8'h04, 8'h80);
    chk("ref_sel", 1'b1, ref_select_o);
    chk("fault_oe", 1'b0, fan_fault_oe_o);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reset_values;
    queue_filter;
    pin_output;
    pct_window;
    rate_change;
    fan_fault;
    close_out;
  end
  // watchdog
  initial
  begin
    #(40 * 20000);
    err_total++;
    close_out;
  end
endmodule // thermal_alert_qualifier_tb_top
